// file: hdl/aes_pkg.sv
package aes_pkg;
   // ----------------------------------------
   // register map (apb, byte addresses)
   // ----------------------------------------
   localparam logic [11:0] AES_CTRL_OFS = 12'h000;      // reporting enables and options
   localparam logic [11:0] AES_SEV_OFS = 12'h004;       // per-error severity, 1 = fatal
   localparam logic [11:0] AES_MASK_OFS = 12'h008;      // per-error mask
   localparam logic [11:0] AES_STAT_OFS = 12'h00c;      // per-error status, write one to clear
   localparam logic [11:0] AES_CNT_OFS = 12'h010;       // message counters and retry count
   // ----------------------------------------
   // control field positions
   // ----------------------------------------
   localparam int CTRL_COR_EN = 0;      // correctable reporting enable
   localparam int CTRL_NF_EN = 1;       // non-fatal reporting enable
   localparam int CTRL_FAT_EN = 2;      // fatal reporting enable
   localparam int CTRL_SERR_EN = 3;     // system error enable
   localparam int CTRL_E2E_CRC_EN = 4;  // end-to-end crc checking enable
   localparam int CTRL_RETRY_MAX_LO = 8;
   localparam int CTRL_RETRY_W = 4;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [7:0] SEV_RST = 8'h00;       // all errors non-fatal after reset
   localparam logic [7:0] MASK_RST = 8'h00;
   // ----------------------------------------
   // error kinds (index into severity, mask, status)
   // ----------------------------------------
   localparam int AES_NERR = 8;
   typedef enum logic [2:0] {
      ERR_CPL_REFUSED,     // completer returns unsupported/abort status
      ERR_ACS_VIOL,        // access-control violation, answered unsupported/abort
      ERR_POISON,          // poisoned tlp
      ERR_E2E_CRC,         // bad end-to-end crc
      ERR_CPL_TIMEOUT,     // completion timeout
      ERR_UNEXP_CPL,       // unexpected completion
      ERR_REFUSED_RCVD,    // requester got unsupported/abort status
      ERR_SPARE
   } aes_err_t;
   typedef enum logic [1:0] {
      ROLE_COMPLETER,
      ROLE_INTERMEDIATE,
      ROLE_ULTIMATE,
      ROLE_REQUESTER
   } aes_role_t;
   typedef enum logic [1:0] {
      MSG_NONE,
      MSG_COR,
      MSG_NONFATAL,
      MSG_FATAL
   } aes_msg_t;
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic valid;              // one-cycle detection pulse
      aes_err_t kind;
      aes_role_t role;
      logic also_unexp;         // same tlp was also an unexpected completion
      logic poison_ok;          // poison handled so operation continues
      logic p2p_no_prop;        // root peer-to-peer, cannot carry error info
      logic retry;              // requester will retry after timeout
   } aes_det_t;
   typedef struct packed {
      logic valid;
      aes_msg_t msg;
      logic drop;               // transaction must not be forwarded
      logic fill_ones;          // return all ones to software
   } aes_dec_t;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [AES_NERR-1:0] sev;
      logic [AES_NERR-1:0] mask;
      logic [AES_NERR-1:0] stat;
      logic [7:0] cor_cnt;
      logic [7:0] nf_cnt;
      logic [7:0] fat_cnt;
      logic [3:0] retries;
      aes_dec_t dec;
      logic [31:0] prdata;
      logic pready;
   } aes_state_t;
endpackage

// file: hdl/aes_advisory.sv
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
// Summary of operation
// RL1: advanced-reporting agent sends cor for advisory case
// RL2: no advanced reporting: advisory case sends nothing
// RL3: completer unsupported/abort non-fatal is advisory
// RL4: access violation answered unsupported/abort is advisory
// RL5: completer may poison data instead
// RL6: routing receiver treats non-fatal error as advisory
// RL7: crc errors ignored when checking off
// RL8: root peer-to-peer without propagation: nonfatal, drop
// RL9: ultimate poisoned receiver continuing is advisory
// RL10: root poison write: cor if propagated
// RL11: requester poisoned read: cor if handled
// RL12: timeout retries finite, then uncorrectable message
// RL13: report advisory before each timeout retry
// RL14: avoid retrying a fatal timeout
// RL15: unexpected completion non-fatal is advisory
// RL16: fatal severity always sends fatal; here only while fatal or system error enable is set and the error is unmasked
// RL17: unexpected plus poisoned reports unexpected only
// RL18: requester handles unsupported/abort completion itself
// RL19: requester logs and sends nothing for it; here its status bit is not set either
// RL20: root may return all ones to software
// RL21: class disabled means no message; here system error enable still sends nonfatal and fatal
// RL22: masked error sets status, sends nothing
// RL23: one message class at most per error
module aes_advisory #(
   parameter bit HAS_ADV_REPORT = 1'b1       // build-time advanced reporting support
) (
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire logic clk_en_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // detection and decision
   input wire aes_pkg::aes_det_t det_in,
   output aes_pkg::aes_dec_t dec_out,
   output logic retry_ok_out
);
   import aes_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   aes_state_t st_ff;       // all registered state
   aes_state_t nxt_st;      // next state

   // decision helper signals
   logic is_fatal;          // programmed severity of this error
   logic advisory;          // case falls into advisory handling
   logic seen;              // error actually detected
   logic [AES_NERR-1:0] hit; // one-hot of the detected kind
   aes_msg_t msg_raw;       // class before enables and mask
   aes_msg_t msg_fin;       // class after enables and mask
   logic cls_en;            // class enabled
   logic retry_lim;         // retries exhausted
   logic apb_acc;           // apb access phase
   logic [3:0] retry_max;

   // ----------------------------------------
   // per-error one-hot decode
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < AES_NERR; gi++) begin : g_hit
         assign hit[gi] = seen && (det_in.kind == aes_err_t'(gi));
      end
   endgenerate

   // ----------------------------------------
   // decision logic
   // ----------------------------------------
   always_comb begin
      retry_max = st_ff.ctrl[CTRL_RETRY_MAX_LO +: CTRL_RETRY_W];
      retry_lim = (st_ff.retries >= retry_max);
      is_fatal = st_ff.sev[det_in.kind];
      seen = det_in.valid;
      advisory = 1'b0;
      msg_raw = MSG_NONE;
      // crc error not seen when checking is off
      if (det_in.kind == ERR_E2E_CRC && !st_ff.ctrl[CTRL_E2E_CRC_EN]) begin
         seen = 1'b0;                                               // [RL7]
      end
      // poison on an unexpected completion is folded into that error
      if (det_in.kind == ERR_POISON && det_in.also_unexp) begin
         seen = 1'b0;                                               // [RL17]
      end
      case (det_in.kind)
         ERR_CPL_REFUSED: advisory = (det_in.role == ROLE_COMPLETER);  // [RL3] [RL5]
         ERR_ACS_VIOL: advisory = (det_in.role == ROLE_COMPLETER);   // [RL4]
         ERR_POISON, ERR_E2E_CRC: begin
            if (det_in.role == ROLE_INTERMEDIATE) begin
               advisory = !det_in.p2p_no_prop;                        // [RL6] [RL8]
            end else begin
               advisory = det_in.poison_ok;                           // [RL9] [RL10] [RL11]
            end
         end
         ERR_CPL_TIMEOUT: advisory = det_in.retry && !retry_lim;     // [RL12] [RL13]
         ERR_UNEXP_CPL: advisory = 1'b1;                              // [RL15]
         default: advisory = 1'b0;
      endcase
      if (det_in.kind == ERR_REFUSED_RCVD && det_in.role == ROLE_REQUESTER) begin
         seen = 1'b0;                                                 // [RL18] [RL19]
      end
      if (is_fatal) begin
         msg_raw = MSG_FATAL;                                         // [RL16]
      end else if (advisory) begin
         msg_raw = HAS_ADV_REPORT ? MSG_COR : MSG_NONE;               // [RL1] [RL2]
      end else begin
         msg_raw = MSG_NONFATAL;
      end
      case (msg_raw)
         MSG_COR: cls_en = st_ff.ctrl[CTRL_COR_EN];
         MSG_NONFATAL: cls_en = st_ff.ctrl[CTRL_NF_EN] || st_ff.ctrl[CTRL_SERR_EN];
         MSG_FATAL: cls_en = st_ff.ctrl[CTRL_FAT_EN] || st_ff.ctrl[CTRL_SERR_EN];
         default: cls_en = 1'b0;
      endcase
      // single class per error, gated by enables and mask
      msg_fin = (seen && cls_en && !st_ff.mask[det_in.kind]) ? msg_raw : MSG_NONE;  // [RL21] [RL22] [RL23]
   end

   // ----------------------------------------
   // next-state logic
   // ----------------------------------------
   always_comb begin
      nxt_st = st_ff;
      apb_acc = psel_in && penable_in;
      nxt_st.pready = psel_in && !penable_in;
      nxt_st.dec = '0;
      // decision output, one cycle
      if (det_in.valid) begin
         nxt_st.dec.valid = 1'b1;
         nxt_st.dec.msg = msg_fin;
         nxt_st.dec.drop = seen && det_in.role == ROLE_INTERMEDIATE && det_in.p2p_no_prop;  // [RL8]
         nxt_st.dec.fill_ones = det_in.kind == ERR_REFUSED_RCVD && det_in.role == ROLE_REQUESTER;  // [RL20]
      end
      // timeout retry bookkeeping
      if (hit[ERR_CPL_TIMEOUT]) begin
         if (advisory && !is_fatal) begin
            nxt_st.retries = 4'(st_ff.retries + 4'h1);                 // [RL12]
         end else begin
            nxt_st.retries = 4'h0;
         end
      end
      case (msg_fin)
         MSG_COR: nxt_st.cor_cnt = 8'(st_ff.cor_cnt + 8'h01);
         MSG_NONFATAL: nxt_st.nf_cnt = 8'(st_ff.nf_cnt + 8'h01);
         MSG_FATAL: nxt_st.fat_cnt = 8'(st_ff.fat_cnt + 8'h01);
         default: nxt_st.cor_cnt = st_ff.cor_cnt;
      endcase
      // apb register access
      if (apb_acc && pwrite_in) begin
         case (paddr_in)
            AES_CTRL_OFS: nxt_st.ctrl = pwdata_in;
            AES_SEV_OFS: nxt_st.sev = pwdata_in[AES_NERR-1:0];
            AES_MASK_OFS: nxt_st.mask = pwdata_in[AES_NERR-1:0];
            AES_STAT_OFS: nxt_st.stat = st_ff.stat & ~pwdata_in[AES_NERR-1:0];
            default: nxt_st.ctrl = st_ff.ctrl;
         endcase
      end
      // status set wins over clear, masked errors still set status
      nxt_st.stat = nxt_st.stat | hit;                                 // [RL22]
      case (paddr_in)
         AES_CTRL_OFS: nxt_st.prdata = st_ff.ctrl;
         AES_SEV_OFS: nxt_st.prdata = {24'h000000, st_ff.sev};
         AES_MASK_OFS: nxt_st.prdata = {24'h000000, st_ff.mask};
         AES_STAT_OFS: nxt_st.prdata = {24'h000000, st_ff.stat};
         AES_CNT_OFS: nxt_st.prdata = {st_ff.retries, 4'h0, st_ff.fat_cnt, st_ff.nf_cnt, st_ff.cor_cnt};
         default: nxt_st.prdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         nxt_st_reset();
      end else if (clk_en_in) begin
         st_ff <= nxt_st;
      end
   end

   task automatic nxt_st_reset();
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RST;
      st_ff.sev <= SEV_RST;
      st_ff.mask <= MASK_RST;
   endtask

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata_out = st_ff.prdata;
   assign pready_out = st_ff.pready;
   assign pslverr_out = 1'b0;
   assign dec_out = st_ff.dec;
   // retry allowed only for non-fatal timeouts under the limit
   assign retry_ok_out = !st_ff.sev[ERR_CPL_TIMEOUT] && (st_ff.retries < st_ff.ctrl[CTRL_RETRY_MAX_LO +: CTRL_RETRY_W]);  // [RL14]

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_fatal_det;
      clk_en_in && det_in.valid && seen && st_ff.sev[det_in.kind] && cls_en && !st_ff.mask[det_in.kind];
   endsequence
   fatal_sends_fatal_a: assert property (s_fatal_det |=> dec_out.msg == MSG_FATAL)  // [RL16]
      else $error("fatal severity did not send fatal");
   masked_silent_a: assert property (clk_en_in && det_in.valid && st_ff.mask[det_in.kind] |=> dec_out.msg == MSG_NONE)  // [RL22]
      else $error("masked error sent a message");
   masked_status_a: assert property (clk_en_in && hit[ERR_UNEXP_CPL] |=> st_ff.stat[ERR_UNEXP_CPL])  // [RL22]
      else $error("status not set");
   no_adv_cor_a: assert property (clk_en_in && det_in.valid |=> !(HAS_ADV_REPORT == 1'b0 && dec_out.msg == MSG_COR))  // [RL2]
      else $error("cor sent without advanced reporting");
   req_refused_quiet_a: assert property (clk_en_in && det_in.valid && det_in.kind == ERR_REFUSED_RCVD && det_in.role == ROLE_REQUESTER |=> dec_out.msg == MSG_NONE && dec_out.fill_ones)  // [RL19]
      else $error("requester reported unsupported status");
   crc_off_a: assert property (clk_en_in && det_in.valid && det_in.kind == ERR_E2E_CRC && !st_ff.ctrl[CTRL_E2E_CRC_EN] |=> dec_out.msg == MSG_NONE)  // [RL7]
      else $error("crc error reported while off");
   cor_disabled_a: assert property (clk_en_in && det_in.valid && !st_ff.ctrl[CTRL_COR_EN] |=> dec_out.msg != MSG_COR)  // [RL21]
      else $error("disabled class sent");
   drop_nonfatal_a: assert property (clk_en_in && dec_out.valid && dec_out.drop |-> dec_out.msg != MSG_COR)  // [RL8]
      else $error("dropped transaction sent cor");
endmodule

// file: dv/aes_rc_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// collector of error messages at the root
// ----------------------------------------
module aes_root_model
   import aes_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rstn_in,
   input wire aes_pkg::aes_dec_t dec_in,
   output logic [7:0] n_msg_out,
   output aes_pkg::aes_msg_t last_msg_out,
   output logic last_drop_out
);
   // only real messages count; a none decision never reaches the wire
   always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
         n_msg_out <= 8'h00;
         last_msg_out <= MSG_NONE;
         last_drop_out <= 1'b0;
      end else if (dec_in.valid && dec_in.msg != MSG_NONE) begin
         n_msg_out <= n_msg_out + 8'h01;
         last_msg_out <= dec_in.msg;
         last_drop_out <= dec_in.drop;
      end
   end
endmodule

// file: dv/tb_advisory_error_signaling.sv
`timescale 1ns/10ps
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin errors++; $display("MISMATCH %0t %s", $time, m); end end
module tb_advisory_error_signaling;
   import aes_pkg::*;
   // ----------------------------------------
   // one case: detection inputs and expected outcome
   // ----------------------------------------
   typedef struct packed {
      aes_err_t kind;
      aes_role_t role;
      logic [3:0] flags;   // also_unexp, poison_ok, p2p_no_prop, retry
      logic sev;           // 1 = fatal
      aes_msg_t exp;
      logic drop;
   } aes_row_t;
   logic sys_clk_in, rstn_in, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, retry_ok;
   aes_det_t det;
   aes_dec_t dec, dec2;
   logic [7:0] n1, n2;
   aes_msg_t m1, m2;
   logic d1, d2;
   int errors = 0, n_compared = 0, cyc = 0;
   aes_row_t rows[16] = '{
      '{ERR_CPL_REFUSED, ROLE_COMPLETER, 4'h0, 1'b0, MSG_COR, 1'b0},
      '{ERR_ACS_VIOL, ROLE_COMPLETER, 4'h0, 1'b0, MSG_COR, 1'b0},
      '{ERR_POISON, ROLE_INTERMEDIATE, 4'h0, 1'b0, MSG_COR, 1'b0},
      '{ERR_E2E_CRC, ROLE_INTERMEDIATE, 4'h0, 1'b0, MSG_COR, 1'b0},
      '{ERR_POISON, ROLE_INTERMEDIATE, 4'h2, 1'b0, MSG_NONFATAL, 1'b1},
      '{ERR_POISON, ROLE_ULTIMATE, 4'h4, 1'b0, MSG_COR, 1'b0},
      '{ERR_POISON, ROLE_ULTIMATE, 4'h0, 1'b0, MSG_NONFATAL, 1'b0},
      '{ERR_POISON, ROLE_REQUESTER, 4'h4, 1'b0, MSG_COR, 1'b0},
      '{ERR_CPL_TIMEOUT, ROLE_REQUESTER, 4'h1, 1'b0, MSG_COR, 1'b0},
      '{ERR_CPL_TIMEOUT, ROLE_REQUESTER, 4'h0, 1'b0, MSG_NONFATAL, 1'b0},
      '{ERR_UNEXP_CPL, ROLE_ULTIMATE, 4'h0, 1'b0, MSG_COR, 1'b0},
      '{ERR_POISON, ROLE_ULTIMATE, 4'h8, 1'b0, MSG_NONE, 1'b0},
      '{ERR_REFUSED_RCVD, ROLE_REQUESTER, 4'h0, 1'b0, MSG_NONE, 1'b0},
      '{ERR_CPL_REFUSED, ROLE_COMPLETER, 4'h0, 1'b1, MSG_FATAL, 1'b0},
      '{ERR_POISON, ROLE_INTERMEDIATE, 4'h0, 1'b1, MSG_FATAL, 1'b0},
      '{ERR_CPL_TIMEOUT, ROLE_REQUESTER, 4'h1, 1'b1, MSG_FATAL, 1'b0}
   };
   // ----------------------------------------
   // design with and without advanced reporting, each with a collector
   // ----------------------------------------
   aes_advisory #(.HAS_ADV_REPORT(1'b1)) i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .clk_en_in(1'b1),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(), .det_in(det), .dec_out(dec),
      .retry_ok_out(retry_ok));
   aes_advisory #(.HAS_ADV_REPORT(1'b0)) i_dut_basic (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .clk_en_in(1'b1),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(), .pready_out(), .pslverr_out(), .det_in(det), .dec_out(dec2), .retry_ok_out());
   aes_root_model i_root (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .dec_in(dec), .n_msg_out(n1),
      .last_msg_out(m1), .last_drop_out(d1));
   aes_root_model i_root2 (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .dec_in(dec2), .n_msg_out(n2),
      .last_msg_out(m2), .last_drop_out(d2));
   // clock and hang guard
   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // apb transfer: setup, then access held until pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_in);
      penable <= 1'b1;
      // wait for ready; only the bench timeout ends a hang
      do begin
         @(posedge sys_clk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following call never re-drives psel in this step
      @(posedge sys_clk_in);
   endtask
   // message seen by a collector over one detection
   function automatic logic [1:0] seen(input logic [7:0] dn, input logic [1:0] m);
      return (dn == 8'd0) ? MSG_NONE : ((dn == 8'd1) ? m : 2'bxx);
   endfunction
   // program severity, pulse one detection, check both collectors
   task automatic run(input aes_row_t r);
      logic [7:0] a1, a2;
      apb(1'b1, AES_SEV_OFS, 32'(r.sev) << r.kind);
      a1 = n1;
      a2 = n2;
      det <= '{1'b1, r.kind, r.role, r.flags[3], r.flags[2], r.flags[1], r.flags[0]};
      @(posedge sys_clk_in);
      det.valid <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      `CHK(seen(n1 - a1, m1), r.exp, "message class")
      `CHK(seen(n2 - a2, m2), (r.exp == MSG_COR) ? MSG_NONE : r.exp, "message without advanced reporting")
      if (r.exp != MSG_NONE) `CHK(d1, r.drop, "drop flag")
   endtask
   initial begin
      rstn_in <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 12'h000;
      pwdata <= 32'h0;
      det <= '0;
      repeat (8) @(posedge sys_clk_in);
      rstn_in <= 1'b1;
      @(posedge sys_clk_in);
      // reset values, then an unmapped word that reads zero
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         `CHK(rd, 32'h0, "reset value")
      end
      apb(1'b1, 12'h020, 32'hffff_ffff);
      apb(1'b0, 12'h020, 32'h0);
      `CHK(rd, 32'h0, "unmapped read")
      // all classes enabled, crc checking on, retry limit 2
      apb(1'b1, AES_CTRL_OFS, 32'h0000_021f);
      repeat (2) @(posedge sys_clk_in);
      `CHK(retry_ok, 1'b1, "retry allowed")
      foreach (rows[i]) run(rows[i]);
      repeat (2) @(posedge sys_clk_in);
      `CHK(retry_ok, 1'b0, "no retry when fatal")
      // masked error: status set, nothing sent, then cleared
      apb(1'b1, AES_MASK_OFS, 32'h1 << ERR_POISON);
      run('{ERR_POISON, ROLE_ULTIMATE, 4'h0, 1'b0, MSG_NONE, 1'b0});
      apb(1'b0, AES_STAT_OFS, 32'h0);
      `CHK(rd[ERR_POISON], 1'b1, "masked status")
      apb(1'b1, AES_STAT_OFS, 32'h1 << ERR_POISON);
      apb(1'b0, AES_STAT_OFS, 32'h0);
      `CHK(rd[ERR_POISON], 1'b0, "status clear")
      apb(1'b1, AES_MASK_OFS, 32'h0);
      // disabled classes and crc checking off
      apb(1'b1, AES_CTRL_OFS, 32'h0000_0215);
      run('{ERR_POISON, ROLE_ULTIMATE, 4'h0, 1'b0, MSG_NONE, 1'b0});
      apb(1'b1, AES_CTRL_OFS, 32'h0000_021e);
      run('{ERR_CPL_REFUSED, ROLE_COMPLETER, 4'h0, 1'b0, MSG_NONE, 1'b0});
      apb(1'b1, AES_CTRL_OFS, 32'h0000_020f);
      run('{ERR_E2E_CRC, ROLE_INTERMEDIATE, 4'h0, 1'b0, MSG_NONE, 1'b0});
      // retry limit 2: two advisory retries, then the uncorrectable message
      apb(1'b1, AES_CTRL_OFS, 32'h0000_021f);
      run('{ERR_CPL_TIMEOUT, ROLE_REQUESTER, 4'h1, 1'b0, MSG_COR, 1'b0});
      run('{ERR_CPL_TIMEOUT, ROLE_REQUESTER, 4'h1, 1'b0, MSG_COR, 1'b0});
      run('{ERR_CPL_TIMEOUT, ROLE_REQUESTER, 4'h1, 1'b0, MSG_NONFATAL, 1'b0});
      summarize();
   end
endmodule
